// ---- hdl/wsk_pkg.sv ----
/*
  Package for the weigh status and key block: register map, field
  positions, reset values, key indices, display states and timing.
  Assumes a 10 MHz system clock and a byte-addressed Avalon-MM bus.
*/
package wsk_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WT_W = 24;
  localparam int ADDR_W = 8;
  localparam int DIGITS = 6;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UPPER = 8'h04;
  localparam logic [7:0] OFS_LOWER = 8'h08;
  localparam logic [7:0] OFS_TARGET = 8'h0c;
  localparam logic [7:0] OFS_OVER = 8'h10;
  localparam logic [7:0] OFS_UNDER = 8'h14;
  localparam logic [7:0] OFS_FINAL = 8'h18;
  localparam logic [7:0] OFS_SP1 = 8'h1c;
  localparam logic [7:0] OFS_NEAR = 8'h20;
  localparam logic [7:0] OFS_ZRANGE = 8'h24;
  localparam logic [7:0] OFS_DIV = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_WEIGHT = 8'h30;
  localparam logic [7:0] OFS_EDIT = 8'h34;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int F_CMP = 0;
  localparam int F_NZSEL = 2;
  localparam int F_QDIV = 3;
  localparam int F_APM = 4;
  localparam int F_COMM = 8;
  localparam int F_FKD_TARE = 12;
  localparam int F_FKD_ZERO = 13;
  localparam int F_FKD_GN = 14;
  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int ST_LAMPS = 0;
  localparam int ST_DISP = 16;
  localparam int ST_MODE = 18;
  localparam int ST_ITEM = 20;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [23:0] SETPT_RST = 24'h00_0000;
  localparam logic [23:0] DIV_RST = 24'h00_0001;
  // ----------------------------------------------------------------
  // Modes and keys
  // ----------------------------------------------------------------
  localparam logic [1:0] CMP_LIMIT = 2'h0;
  localparam logic [1:0] CMP_OVER = 2'h1;
  localparam logic [1:0] CMP_DISCH = 2'h2;
  localparam logic [1:0] APM_OFF = 2'h0;
  localparam logic [1:0] APM_HOLD = 2'h2;
  localparam logic [2:0] COMM_MIN = 3'h4;
  localparam logic [2:0] COMM_MAX = 3'h6;
  localparam int K_MODE = 0;
  localparam int K_ESC = 1;
  localparam int K_TARE = 2;
  localparam int K_UP = 3;
  localparam int K_ZERO = 4;
  localparam int K_DOWN = 5;
  localparam int K_GN = 6;
  localparam int K_RIGHT = 7;
  localparam int K_PRINT = 8;
  localparam int K_ENTER = 9;
  localparam int K_LOCK = 10;
  localparam int NKEY = 11;
  typedef enum logic [1:0] {
    DISP_WEIGHT, DISP_MODE, DISP_ITEM, DISP_EDIT
  } wsk_disp_t;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
endpackage

// ---- hdl/wsk_top.sv ----
/*
  Status lamps and front panel keys of a load-cell weighing indicator.
  Assumes the weighing engine delivers signed samples on the same clock,
  keys and the lock switch arrive as raw pins, and software sets up the
  set points over Avalon-MM.
*/
`timescale 1ns/1ps
// How it works
// - Mode 0: high above upper, pass in limits inclusive, low below lower.
// - Mode 1: same bands around target plus over, minus under.
// - Mode 2: done lamp follows the completion signal.
// - Mode 2: second lamp at final compensation, first at set point one.
// - First set point zero keeps its lamp dark.
// - Near lamp when chosen weight at or below near setting.
// - Hold lamp while held, only with auto print mode 2.
// - Zero alarm lamp flashes when zero total exceeds range limit.
// - Net lamp on while net shown, off while gross shown.
// - Centre lamp within a quarter division of true zero.
// - Quarter option adds centre of every displayed interval.
// - Mode key enters setting display, presses cycle modes 0 to 3.
// - Escape from mode or item display returns to weight.
// - Tare takes load as tare, lights tare lamp; print with tare held clears alarm.
// - Zero key zeros gross, beyond limit subtracts limit and alarms.
// - Up and down step item, or change selected digit by one.
// - Gross/net key toggles display while weight shown.
// - Right key advances mode, or moves selected digit.
// - Print sends record only with auto print 0, comm mode 4-6.
// - Enter starts editing an item, then commits the value.
// - Disable bits suppress tare, zero and gross/net keys.
// - Lock switch on rejects any setting change.
module wsk_top #(
  parameter int P_FLASH_HALF_CYC = wsk_pkg::FLASH_HALF_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [wsk_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic [wsk_pkg::WT_W-1:0] i_raw_weight,
  input wire logic i_sample_valid,
  input wire logic i_complete,
  input wire logic i_stable,
  input wire logic i_hold,
  input wire logic i_key_mode,
  input wire logic i_escape_key,
  input wire logic i_key_tare,
  input wire logic i_key_up,
  input wire logic i_key_zero,
  input wire logic i_key_down,
  input wire logic i_key_gross_net,
  input wire logic i_key_right,
  input wire logic i_key_print,
  input wire logic i_key_enter,
  input wire logic i_lock_switch,
  output logic o_high_band_lamp,
  output logic o_pass_band_lamp,
  output logic o_low_band_lamp,
  output logic o_discharge_done_lamp,
  output logic o_second_setpoint_lamp,
  output logic o_first_setpoint_lamp,
  output logic o_near_empty_lamp,
  output logic o_hold_lamp,
  output logic o_zeroing_alarm_lamp,
  output logic o_steady_weight_lamp,
  output logic o_tare_lamp,
  output logic o_net_lamp,
  output logic o_centre_zero_lamp,
  output logic o_print_req,
  output logic o_commit_valid,
  output logic [1:0] o_commit_mode,
  output logic [7:0] o_commit_item,
  output logic [wsk_pkg::WT_W-1:0] o_commit_value
);
  import wsk_pkg::*;

  function automatic logic [WT_W-1:0] mag(input logic signed [WT_W-1:0] v);
    mag = v[WT_W-1] ? WT_W'(-v) : v;
  endfunction

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  logic [NKEY-1:0] pins, k1_reg, k2_reg, k3_reg, press, held;
  assign pins = {i_lock_switch, i_key_enter, i_key_print, i_key_right,
                 i_key_gross_net, i_key_down, i_key_zero, i_key_up,
                 i_key_tare, i_escape_key, i_key_mode};
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      k1_reg <= '0;
      k2_reg <= '0;
      k3_reg <= '0;
    end else begin
      k1_reg <= pins;
      k2_reg <= k1_reg;
      k3_reg <= k2_reg;
    end
  end
  assign held = k2_reg;
  assign press = k2_reg & ~k3_reg;
  logic lock;
  assign lock = held[K_LOCK];

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, ctrl_next, rdata_next;
  logic [WT_W-1:0] cfg_reg [OFS_UPPER[7:2]:OFS_DIV[7:2]];
  logic [WT_W-1:0] cfg_next [OFS_UPPER[7:2]:OFS_DIV[7:2]];
  logic wait_next, wr_go;
  logic [31:0] status;
  logic signed [WT_W-1:0] shown;
  logic [WT_W-1:0] edit_reg;
  assign wr_go = i_write && !o_waitrequest;
  always_comb begin
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    wait_next = !((i_read || i_write) && o_waitrequest);
    rdata_next = o_readdata;
    // Settings freeze while locked, so a bus write cannot slip past it
    if (wr_go && !lock) begin
      if (i_address == OFS_CTRL) ctrl_next = i_writedata;
      else if (i_address >= OFS_UPPER && i_address <= OFS_DIV &&
               i_address[1:0] == 2'h0)
        cfg_next[i_address[7:2]] = i_writedata[WT_W-1:0];
    end
    if (i_read && o_waitrequest) begin
      rdata_next = 32'h0;
      if (i_address == OFS_CTRL) rdata_next = ctrl_reg;
      else if (i_address >= OFS_UPPER && i_address <= OFS_DIV &&
               i_address[1:0] == 2'h0)
        rdata_next = {8'h0, cfg_reg[i_address[7:2]]};
      else if (i_address == OFS_STATUS) rdata_next = status;
      else if (i_address == OFS_WEIGHT) rdata_next = 32'(shown);
      else if (i_address == OFS_EDIT) rdata_next = {8'h0, edit_reg};
    end
  end
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      for (int i = OFS_UPPER[7:2]; i <= OFS_DIV[7:2]; i++)
        cfg_reg[i] <= (i == OFS_DIV[7:2]) ? DIV_RST : SETPT_RST;
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      o_waitrequest <= wait_next;
      o_readdata <= rdata_next;
    end
  end
  logic [1:0] cmp_mode, apm;
  logic [2:0] comm;
  assign cmp_mode = ctrl_reg[F_CMP +: 2];
  assign apm = ctrl_reg[F_APM +: 2];
  assign comm = ctrl_reg[F_COMM +: 3];

  // ----------------------------------------------------------------
  // Weighing state: zero, tare, gross/net, alarms, print
  // ----------------------------------------------------------------
  logic signed [WT_W-1:0] raw_reg, zoff_reg, tare_reg, gross, net;
  logic signed [WT_W-1:0] raw_next, zoff_next, tare_next;
  logic net_reg, net_next, tared_reg, tared_next;
  logic zeroing_alarm_lamp_reg, zeroing_alarm_lamp_next, talm_reg, talm_next, prt_next;
  logic tare_go, zero_go, gn_go, zero_over;
  logic signed [WT_W:0] zsum;
  logic [WT_W-1:0] dz;
  wsk_disp_t disp_reg, disp_next;
  assign dz = cfg_reg[OFS_ZRANGE[7:2]];
  assign gross = raw_reg - zoff_reg;
  assign net = gross - tare_reg;
  assign shown = net_reg ? net : gross;
  assign tare_go = press[K_TARE] && !ctrl_reg[F_FKD_TARE];
  assign zero_go = press[K_ZERO] && !ctrl_reg[F_FKD_ZERO];
  assign gn_go = press[K_GN] && !ctrl_reg[F_FKD_GN] &&
                 disp_reg == DISP_WEIGHT;
  assign zsum = (WT_W+1)'(zoff_reg) + (WT_W+1)'(gross);
  assign zero_over = (zsum[WT_W] ? -zsum : zsum) > (WT_W+1)'(dz);
  always_comb begin
    raw_next = i_sample_valid ? i_raw_weight : raw_reg;
    zoff_next = zoff_reg;
    tare_next = tare_reg;
    tared_next = tared_reg;
    net_next = net_reg;
    if (zero_go) begin
      // Beyond the range only the limit itself is taken off
      if (zero_over) zoff_next = gross[WT_W-1] ? zoff_reg - dz
                                               : zoff_reg + dz;
      else zoff_next = zsum[WT_W-1:0];
    end
    if (tare_go) begin
      tare_next = gross;
      tared_next = 1'b1;
    end
    if (gn_go) net_next = !net_reg;
    // Set wins over clear for both alarms
    zeroing_alarm_lamp_next = (zero_go && zero_over) ||
                (zeroing_alarm_lamp_reg && !(press[K_PRINT] && held[K_ZERO]));
    talm_next = (tare_go && gross[WT_W-1]) ||
                (talm_reg && !(press[K_PRINT] && held[K_TARE]));
    prt_next = press[K_PRINT] && !held[K_TARE] && !held[K_ZERO] &&
               apm == APM_OFF && comm >= COMM_MIN &&
               comm <= COMM_MAX;
  end
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      raw_reg <= '0;
      zoff_reg <= '0;
      tare_reg <= '0;
      tared_reg <= 1'b0;
      net_reg <= 1'b0;
      zeroing_alarm_lamp_reg <= 1'b0;
      talm_reg <= 1'b0;
      o_print_req <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      zoff_reg <= zoff_next;
      tare_reg <= tare_next;
      tared_reg <= tared_next;
      net_reg <= net_next;
      zeroing_alarm_lamp_reg <= zeroing_alarm_lamp_next;
      talm_reg <= talm_next;
      o_print_req <= prt_next;
    end
  end

  // ----------------------------------------------------------------
  // Display navigation and value editing
  // ----------------------------------------------------------------
  logic [1:0] mode_reg, mode_next;
  logic [7:0] item_reg, item_next;
  logic [2:0] dig_reg, dig_next;
  logic [WT_W-1:0] edit_next;
  logic rej_reg, rej_next, com_next;
  logic [3:0] d;
  always_comb begin
    disp_next = disp_reg;
    mode_next = mode_reg;
    item_next = item_reg;
    dig_next = dig_reg;
    edit_next = edit_reg;
    rej_next = rej_reg;
    com_next = 1'b0;
    d = edit_reg[dig_reg*4 +: 4];
    unique case (disp_reg)
      DISP_WEIGHT: if (press[K_MODE]) begin
        disp_next = DISP_MODE;
        mode_next = 2'h0;
      end
      DISP_MODE: begin
        if (press[K_ESC]) disp_next = DISP_WEIGHT;
        else if (press[K_MODE] || press[K_RIGHT])
          mode_next = mode_reg + 2'h1;
        else if (press[K_UP] || press[K_DOWN]) begin
          disp_next = DISP_ITEM;
          item_next = 8'h0;
        end
      end
      DISP_ITEM: begin
        if (press[K_ESC]) disp_next = DISP_WEIGHT;
        else if (press[K_UP]) item_next = item_reg + 8'h1;
        else if (press[K_DOWN]) item_next = item_reg - 8'h1;
        else if (press[K_ENTER]) begin
          disp_next = DISP_EDIT;
          edit_next = '0;
          dig_next = 3'h0;
        end
      end
      DISP_EDIT: begin
        if (press[K_ESC]) disp_next = DISP_WEIGHT;
        else if (press[K_UP])
          edit_next[dig_reg*4 +: 4] = (d == 4'h9) ? 4'h0 : d + 4'h1;
        else if (press[K_DOWN])
          edit_next[dig_reg*4 +: 4] = (d == 4'h0) ? 4'h9 : d - 4'h1;
        else if (press[K_RIGHT])
          dig_next = (dig_reg == 3'(DIGITS-1)) ? 3'h0
                                               : dig_reg + 3'h1;
        else if (press[K_ENTER]) begin
          disp_next = DISP_ITEM;
          com_next = !lock;
          rej_next = lock;
        end
      end
    endcase
  end
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      disp_reg <= DISP_WEIGHT;
      mode_reg <= 2'h0;
      item_reg <= 8'h0;
      dig_reg <= 3'h0;
      edit_reg <= '0;
      rej_reg <= 1'b0;
      o_commit_valid <= 1'b0;
      o_commit_mode <= 2'h0;
      o_commit_item <= 8'h0;
      o_commit_value <= '0;
    end else begin
      disp_reg <= disp_next;
      mode_reg <= mode_next;
      item_reg <= item_next;
      dig_reg <= dig_next;
      edit_reg <= edit_next;
      rej_reg <= rej_next;
      o_commit_valid <= com_next;
      if (com_next) begin
        o_commit_mode <= mode_reg;
        o_commit_item <= item_reg;
        o_commit_value <= edit_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash divider: phase toggles each half period
  // ----------------------------------------------------------------
  logic [31:0] fcnt_reg, fcnt_next;
  logic phase_reg, phase_next;
  always_comb begin
    fcnt_next = fcnt_reg + 32'h1;
    phase_next = phase_reg;
    if (fcnt_reg >= 32'(P_FLASH_HALF_CYC - 1)) begin
      fcnt_next = 32'h0;
      phase_next = !phase_reg;
    end
  end
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_reg <= 32'h0;
      phase_reg <= 1'b0;
    end else begin
      fcnt_reg <= fcnt_next;
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------------------------------
  // Lamps, evaluated every cycle from the latest sample
  // ----------------------------------------------------------------
  logic signed [WT_W+1:0] w, up, lo, hi1, lo1;
  logic [WT_W-1:0] aw, divv, rem, sp1;
  logic [13:0] lamp_next, lamps;
  logic in_q;
  assign w = (WT_W+2)'(shown);
  assign sp1 = cfg_reg[OFS_SP1[7:2]];
  assign divv = cfg_reg[OFS_DIV[7:2]];
  assign aw = mag(shown);
  // Modulo is costly but the division is a free setting, not a power of 2
  assign rem = (divv == '0) ? aw : aw % divv;
  always_comb begin
    up = (WT_W+2)'($signed(cfg_reg[OFS_UPPER[7:2]]));
    lo = (WT_W+2)'($signed(cfg_reg[OFS_LOWER[7:2]]));
    hi1 = (WT_W+2)'($signed(cfg_reg[OFS_TARGET[7:2]])) +
          (WT_W+2)'($signed(cfg_reg[OFS_OVER[7:2]]));
    lo1 = (WT_W+2)'($signed(cfg_reg[OFS_TARGET[7:2]])) -
          (WT_W+2)'($signed(cfg_reg[OFS_UNDER[7:2]]));
    lamp_next = '0;
    in_q = {aw, 2'h0} <= {2'h0, divv};
    if (ctrl_reg[F_QDIV])
      in_q = in_q || ({rem, 2'h0} <= {2'h0, divv}) ||
             ({divv - rem, 2'h0} <= {2'h0, divv});
    unique case (cmp_mode)
      CMP_LIMIT: begin
        lamp_next[0] = w > up;
        lamp_next[1] = w >= lo && w <= up;
        lamp_next[2] = w < lo;
      end
      CMP_OVER: begin
        lamp_next[0] = w > hi1;
        lamp_next[1] = w >= lo1 && w <= hi1;
        lamp_next[2] = w < lo1;
      end
      CMP_DISCH: begin
        lamp_next[3] = i_complete;
        lamp_next[4] = w >=
                       (WT_W+2)'($signed(cfg_reg[OFS_FINAL[7:2]]));
        lamp_next[5] = sp1 != '0 &&
                       w >= (WT_W+2)'($signed(sp1));
      end
      default: lamp_next[2:0] = 3'h0;
    endcase
    lamp_next[6] = (ctrl_reg[F_NZSEL] ? net : gross) <=
                   $signed(cfg_reg[OFS_NEAR[7:2]]);
    lamp_next[7] = i_hold && apm == APM_HOLD;
    lamp_next[8] = (zeroing_alarm_lamp_reg || mag(zoff_reg) > dz) && phase_reg;
    lamp_next[9] = i_stable;
    lamp_next[10] = tared_reg;
    lamp_next[11] = net_reg;
    lamp_next[12] = in_q;
    lamp_next[13] = talm_reg;
  end
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) lamps <= '0;
    else lamps <= lamp_next;
  end
  assign {o_centre_zero_lamp, o_net_lamp, o_tare_lamp,
          o_steady_weight_lamp, o_zeroing_alarm_lamp, o_hold_lamp,
          o_near_empty_lamp, o_first_setpoint_lamp,
          o_second_setpoint_lamp, o_discharge_done_lamp,
          o_low_band_lamp, o_pass_band_lamp,
          o_high_band_lamp} = lamps[12:0];
  always_comb begin
    status = 32'h0;
    status[ST_LAMPS +: 16] = {rej_reg, zeroing_alarm_lamp_reg, lamps};
    status[ST_DISP +: 2] = disp_reg;
    status[ST_MODE +: 2] = mode_reg;
    status[ST_ITEM +: 8] = item_reg;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);
  sequence s_gn_taken;
    gn_go;
  endsequence
  sequence s_net_flipped;
    (net_reg != $past(net_reg)) ##1 (o_net_lamp == net_reg);
  endsequence
  a_mode_low_band: assert property (
    cmp_mode == CMP_LIMIT && w < lo |=> o_low_band_lamp)
    else $error("low band lamp not lit below lower limit");
  a_over_high_band: assert property (
    cmp_mode == CMP_OVER && w > hi1 |=> o_high_band_lamp && !o_pass_band_lamp)
    else $error("high band lamp wrong in over mode");
  a_done_follows: assert property (
    cmp_mode == CMP_DISCH |=> o_discharge_done_lamp == $past(i_complete))
    else $error("done lamp does not follow completion");
  a_sp1_dark: assert property (
    o_first_setpoint_lamp |-> $past(sp1) != '0)
    else $error("first set point lamp lit with zero set point");
  a_hold_gate: assert property (
    o_hold_lamp |-> $past(apm) == APM_HOLD && $past(i_hold))
    else $error("hold lamp lit without hold mode");
  a_net_toggle: assert property (
    s_gn_taken |=> s_net_flipped)
    else $error("gross/net key did not toggle display");
  a_escape_return: assert property (
    press[K_ESC] && (disp_reg == DISP_MODE || disp_reg == DISP_ITEM)
    |=> disp_reg == DISP_WEIGHT)
    else $error("escape did not return to weight display");
  a_mode_step: assert property (
    disp_reg == DISP_MODE && press[K_MODE] && !press[K_ESC]
    |=> mode_reg == $past(mode_reg) + 2'h1)
    else $error("mode key did not advance mode");
  a_lock_commit: assert property (
    o_commit_valid |-> !$past(lock))
    else $error("value committed while locked");
  a_print_gate: assert property (
    o_print_req |-> $past(apm) == APM_OFF && $past(comm) >= COMM_MIN &&
    $past(comm) <= COMM_MAX)
    else $error("print sent with wrong settings");
  a_zero_alarm: assert property (
    zero_go && zero_over |=> zeroing_alarm_lamp_reg [*2])
    else $error("zero beyond limit raised no alarm");
  a_bus_answer: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus request not answered in one cycle");
endmodule

// ---- sim/wsk_operator.sv ----
/* Operator model: presses one key for two cycles, works the lock.
   Assumes the bench asks for one press at a time. */
`timescale 1ns/1ps
module wsk_operator (
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [3:0] i_key,
  input wire logic i_lock,
  output logic [10:0] o_pins
);
  import wsk_pkg::*;
  logic [1:0] left = '0;
  logic [3:0] sel = '0;
  // Two cycles so the press survives the two-flop sync
  always @(posedge i_clock) begin
    if (i_go) sel <= i_key;
    left <= i_go ? 2'h2 : left - 2'(left != 0);
  end
  always_comb begin
    o_pins = '0;
    o_pins[sel] = left != 0;
    o_pins[K_LOCK] = i_lock;
  end
endmodule

// ---- sim/wsk_top_bench.sv ----
/* Bench for the weigh status and key block.
   Assumes the operator model and an Avalon master built from tasks. */
`timescale 1ns/1ps
module wsk_top_bench;
  import wsk_pkg::*;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, sv = 0, go = 0, lk = 0;
  logic cp = 0, st = 0, hd = 0;
  logic [7:0] adr = '0;
  logic [31:0] wd = '0, rdat;
  logic [23:0] wt = '0;
  logic [3:0] ks = '0;
  logic [15:0] lf = 16'h6df8;
  wire [10:0] pn;
  wire [12:0] lm;
  wire [31:0] rdo;
  wire [23:0] cval;
  wire [7:0] ci;
  wire [1:0] cm;
  wire wq, pr, cv;
  int error_cnt = 0, checks_done = 0, cyc = 0, prc = 0, cvc = 0;
  wsk_operator op (.i_clock(clk), .i_go(go), .i_key(ks), .i_lock(lk),
    .o_pins(pn));
  wsk_top #(.P_FLASH_HALF_CYC(4)) DUT (.i_clock(clk), .i_rst_b(rst_b),
    .i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd),
    .o_readdata(rdo), .o_waitrequest(wq), .i_raw_weight(wt),
    .i_sample_valid(sv), .i_complete(cp), .i_stable(st), .i_hold(hd),
    .i_key_mode(pn[K_MODE]), .i_escape_key(pn[K_ESC]),
    .i_key_tare(pn[K_TARE]), .i_key_up(pn[K_UP]), .i_key_zero(pn[K_ZERO]),
    .i_key_down(pn[K_DOWN]), .i_key_gross_net(pn[K_GN]),
    .i_key_right(pn[K_RIGHT]), .i_key_print(pn[K_PRINT]),
    .i_key_enter(pn[K_ENTER]), .i_lock_switch(pn[K_LOCK]),
    .o_high_band_lamp(lm[0]), .o_pass_band_lamp(lm[1]),
    .o_low_band_lamp(lm[2]), .o_discharge_done_lamp(lm[3]),
    .o_second_setpoint_lamp(lm[4]), .o_first_setpoint_lamp(lm[5]),
    .o_near_empty_lamp(lm[6]), .o_hold_lamp(lm[7]),
    .o_zeroing_alarm_lamp(lm[8]), .o_steady_weight_lamp(lm[9]),
    .o_tare_lamp(lm[10]), .o_net_lamp(lm[11]), .o_centre_zero_lamp(lm[12]),
    .o_print_req(pr), .o_commit_valid(cv), .o_commit_mode(cm),
    .o_commit_item(ci), .o_commit_value(cval));
  always #50 clk = ~clk;
  // Whole run needs about five hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (pr === 1'b1) prc++;
    if (cv === 1'b1) cvc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wq !== 1'b0);
    rdat = rdo;
    wr <= 0;
    rd <= 0;
  endtask
  task smp(input int w);
    @(posedge clk);
    wt <= w[23:0];
    sv <= 1;
    cp <= lf[0];
    st <= lf[1];
    hd <= lf[2];
    @(posedge clk);
    sv <= 0;
    repeat (3) @(posedge clk);
  endtask
  task key(input int k);
    @(posedge clk);
    ks <= k[3:0];
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (8) @(posedge clk);
  endtask
  task band(input int up, lo);
    int w;
    for (int i = 0; i < 14; i++) begin
      lf = nx(lf);
      w = i == 0 ? up : i == 1 ? up + 1 : i == 2 ? lo : i == 3 ? lo - 1
        : i == 4 ? 0 : int'($signed(lf[8:0]));
      smp(w);
      chk("band", {w < lo, w >= lo && w <= up, w > up}, lm[2:0]);
      chk("near", w <= 10, lm[6]);
      chk("centre", w == 0, lm[12]);
    end
    $display("band test done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    int p0;
    repeat (4) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    bus(0, OFS_DIV, 0);
    chk("div", 32'h1, rdat);
    bus(0, 8'hfc, 0);
    chk("unmapped", 32'h0, rdat);
    bus(1, OFS_NEAR, 10);
    bus(1, OFS_UPPER, 100);
    bus(1, OFS_LOWER, 32'h00ff_ffce);
    band(100, -50);
    bus(1, OFS_CTRL, 32'h1);
    bus(1, OFS_TARGET, 20);
    bus(1, OFS_OVER, 5);
    bus(1, OFS_UNDER, 7);
    band(25, 13);
    bus(1, OFS_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      p0 = int'($signed(lf[8:0]));
      smp(p0);
      chk("done", cp, lm[3]);
      chk("sp1", 0, lm[5]);
      chk("sp2", p0 >= 0, lm[4]);
      chk("hold", 0, lm[7]);
      chk("steady", st, lm[9]);
    end
    bus(1, OFS_SP1, 50);
    smp(60);
    chk("sp1", 1, lm[5]);
    key(K_TARE);
    chk("tare", 1, lm[10]);
    key(K_GN);
    chk("net", 1, lm[11]);
    bus(0, OFS_WEIGHT, 0);
    chk("net zero", 0, rdat);
    key(K_GN);
    chk("net", 0, lm[11]);
    bus(1, OFS_CTRL, 32'h4000);
    key(K_GN);
    chk("net", 0, lm[11]);
    $display("key test done");
    key(K_MODE);
    bus(0, OFS_STATUS, 0);
    chk("state", 4'h1, rdat[19:16]);
    key(K_RIGHT);
    bus(0, OFS_STATUS, 0);
    chk("state", 4'h5, rdat[19:16]);
    key(K_MODE);
    bus(0, OFS_STATUS, 0);
    chk("state", 4'h9, rdat[19:16]);
    key(K_ESC);
    bus(0, OFS_STATUS, 0);
    chk("disp", 0, rdat[17:16]);
    key(K_MODE);
    key(K_UP);
    key(K_UP);
    key(K_ENTER);
    key(K_UP);
    key(K_RIGHT);
    key(K_DOWN);
    key(K_ENTER);
    chk("commit", 32'h0100_0091, {ci, cval});
    chk("commits", 1, cvc);
    chk("commit mode", 0, cm);
    bus(1, OFS_CTRL, 32'h0400);
    p0 = prc;
    key(K_PRINT);
    chk("print", p0 + 1, prc);
    bus(1, OFS_CTRL, 32'h0300);
    key(K_PRINT);
    chk("print", p0 + 1, prc);
    bus(1, OFS_DIV, 8);
    bus(1, OFS_CTRL, 32'h28);
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      smp(i == 0 ? 17 : i == 1 ? 20 : 14);
      chk("centre", i != 1, lm[12]);
      chk("hold", hd, lm[7]);
    end
    bus(1, OFS_ZRANGE, 10);
    smp(25);
    key(K_ZERO);
    bus(0, OFS_WEIGHT, 0);
    chk("zeroed", 15, rdat);
    p0 = 0;
    repeat (8) @(posedge clk) p0 += lm[8];
    chk("zeroing_alarm_lamp", 4, p0);
    lk <= 1;
    repeat (4) @(posedge clk);
    bus(1, OFS_UPPER, 7);
    bus(0, OFS_UPPER, 0);
    chk("locked", 100, rdat);
    key(K_ENTER);
    key(K_ENTER);
    chk("commits", 1, cvc);
    bus(0, OFS_STATUS, 0);
    chk("reject", 1, rdat[15]);
    $display("menu test done");
    end_of_test;
  end
endmodule
